/* design/xca_pkg.sv */
package xca_pkg;

   // Address window of the on-chip RAM and CAN block
   localparam logic [15:0] XCA_WIN_LO      = 16'hF700;
   localparam logic [15:0] XCA_WIN_HI      = 16'hFFFF;
   localparam logic [7:0]  XCA_WIN_PAGE    = 8'hF7;
   localparam logic [7:0]  XCA_CAN_PAGE    = 8'hF7;
   localparam int          XCA_RAM_BYTES   = 2048;
   localparam int          XCA_CAN_BYTES   = 256;
   localparam int          XCA_RAM_AW      = 11;

   // APB register byte addresses
   localparam logic [7:0]  XCA_OFS_SYSCTL  = 8'h00;
   localparam logic [7:0]  XCA_OFS_PAGE    = 8'h04;
   localparam logic [7:0]  XCA_OFS_STATUS  = 8'h08;

   // Field positions of system_control
   localparam int          XCA_BIT_GDIS    = 0;
   localparam int          XCA_BIT_VIS     = 1;
   // Field positions of the status register
   localparam int          XCA_BIT_ONCHIP  = 0;
   localparam int          XCA_BIT_CAN     = 1;
   localparam int          XCA_BIT_EA      = 2;

   // Reset values
   localparam logic        XCA_RST_GDIS    = 1'b1;
   localparam logic        XCA_RST_VIS     = 1'b0;
   localparam logic [7:0]  XCA_RST_PAGE    = 8'h00;

   // One external data move request from the CPU
   typedef struct packed {
      logic        use_pointer;
      logic        write;
      logic [15:0] pointer;
      logic [7:0]  index;
      logic [7:0]  wdata;
   } xca_req_s;

   // Routing result of one request
   typedef struct packed {
      logic [15:0] addr;
      logic        onchip;
      logic        can_sel;
      logic        low_port_bus;
      logic        high_port_bus;
      logic        rd_strobe_en;
      logic        wr_strobe_en;
   } xca_route_s;

endpackage

/* design/xca_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module xca_sync
   import xca_pkg::*;
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      sync_out
);

   logic stage1_ff;
   logic stage2_ff;

   // Two stages; the first is read only by the second
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end
      else
      begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;

endmodule
`default_nettype wire

/* design/xca_ram.sv */
`timescale 1ns/10ps
`default_nettype none

module xca_ram
   import xca_pkg::*;
#(
   parameter int DEPTH = XCA_RAM_BYTES,
   parameter int AW    = XCA_RAM_AW
)
(
   input  wire logic          mclk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic [7:0]         rdata
);

   logic [7:0] mem [DEPTH];

   // Data storage needs no reset; contents are undefined at power-up
   always_ff @(posedge mclk)
   begin
      if (wr_en)
      begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];

endmodule
`default_nettype wire

/* design/xca_access_ctrl.sv */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module xca_access_ctrl
   import xca_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // CPU external data move request
   input  wire logic        acc_req,
   input  wire xca_req_s    acc_cmd,
   output logic             acc_done,
   output xca_route_s       acc_route,
   output logic [7:0]       acc_rdata,
   // External access select pin, asynchronous
   input  wire logic        external_access_select_pin
);

   logic        gdis_ff;
   logic        nxt_gdis;
   logic        vis_ff;
   logic        nxt_vis;
   logic [7:0]  page_ff;
   logic [7:0]  nxt_page;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        pready_ff;
   logic        nxt_pready;
   logic        pslverr_ff;
   logic        nxt_pslverr;
   logic        done_ff;
   logic        nxt_done;
   xca_route_s  route_ff;
   xca_route_s  nxt_route;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;
   logic        ea_sync;
   logic        ram_wr;
   logic [7:0]  ram_rdata;
   xca_route_s  dec;
   logic        apb_wr;

   // Register offsets decoded in several places
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == XCA_OFS_SYSCTL) || (a == XCA_OFS_PAGE) || (a == XCA_OFS_STATUS);
   endfunction

   // Pin crosses into mclk before any decode looks at it
   xca_sync u_ea_sync
   (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (external_access_select_pin),
      .sync_out (ea_sync)
   );

   // Routing decode for the request in flight
   always_comb
   begin
      logic hit;
      hit = 1'b0;
      dec = '0;
      if (acc_cmd.use_pointer)
      begin
         dec.addr = acc_cmd.pointer;
         hit      = (acc_cmd.pointer >= XCA_WIN_LO) && (acc_cmd.pointer <= XCA_WIN_HI);
      end
      else
      begin
         dec.addr = {page_ff, acc_cmd.index};
         hit      = (page_ff >= XCA_WIN_PAGE);
      end
      // Disabled window behaves exactly like an address below it
      dec.onchip  = hit && !gdis_ff;
      dec.can_sel = dec.onchip && (dec.addr[15:8] == XCA_CAN_PAGE);
      // Strobes stay idle only for hidden on-chip hits
      dec.rd_strobe_en  = (!dec.onchip || vis_ff) && !acc_cmd.write;
      dec.wr_strobe_en  = (!dec.onchip || vis_ff) && acc_cmd.write;
      // Port 0 leaves the bus only for hidden hits with the pin high
      dec.low_port_bus  = !(dec.onchip && !vis_ff && ea_sync);
      // Indexed moves never use port 2 as a bus
      dec.high_port_bus = acc_cmd.use_pointer && dec.low_port_bus;
   end

   // RAM sits at the upper two kilobytes; CAN page is left to the CAN block
   assign ram_wr = acc_req && acc_cmd.write && dec.onchip && !dec.can_sel;

   xca_ram u_ram
   (
      .mclk  (mclk),
      .wr_en (ram_wr),
      .addr  (dec.addr[XCA_RAM_AW-1:0]),
      .wdata (acc_cmd.wdata),
      .rdata (ram_rdata)
   );

   // Access results are captured one cycle after the request
   always_comb
   begin
      nxt_done  = acc_req;
      nxt_route = route_ff;
      nxt_rdata = rdata_ff;
      if (acc_req)
      begin
         nxt_route = dec;
         nxt_rdata = (dec.onchip && !dec.can_sel && !acc_cmd.write) ? ram_rdata : 8'h00;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         done_ff  <= 1'b0;
         route_ff <= '0;
         rdata_ff <= 8'h00;
      end
      else
      begin
         done_ff  <= nxt_done;
         route_ff <= nxt_route;
         rdata_ff <= nxt_rdata;
      end
   end

   // Write takes effect at the access edge where pready is high
   assign apb_wr = psel && penable && pready_ff && pwrite && is_mapped(paddr);

   // Control register next values
   always_comb
   begin
      nxt_gdis = gdis_ff;
      nxt_vis  = vis_ff;
      nxt_page = page_ff;
      if (apb_wr && (paddr == XCA_OFS_SYSCTL))
      begin
         // Software may only clear gdis; a one written to it later is dropped
         nxt_gdis = gdis_ff && pwdata[XCA_BIT_GDIS];
         nxt_vis  = pwdata[XCA_BIT_VIS];
      end
      if (apb_wr && (paddr == XCA_OFS_PAGE))
      begin
         nxt_page = pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gdis_ff <= XCA_RST_GDIS;
         vis_ff  <= XCA_RST_VIS;
         page_ff <= XCA_RST_PAGE;
      end
      else
      begin
         gdis_ff <= nxt_gdis;
         vis_ff  <= nxt_vis;
         page_ff <= nxt_page;
      end
   end

   // Answer: pready rises in the first access cycle, zero wait states
   always_comb
   begin
      nxt_pready  = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata  = prdata_ff;
      if (psel && !penable)
      begin
         nxt_pready  = 1'b1;
         nxt_pslverr = !is_mapped(paddr);
         nxt_prdata  = 32'h0000_0000;
         if (!pwrite)
         begin
            unique case (paddr)
               XCA_OFS_SYSCTL:
               begin
                  nxt_prdata[XCA_BIT_GDIS] = gdis_ff;
                  nxt_prdata[XCA_BIT_VIS]  = vis_ff;
               end
               XCA_OFS_PAGE:
               begin
                  nxt_prdata[7:0] = page_ff;
               end
               XCA_OFS_STATUS:
               begin
                  nxt_prdata[XCA_BIT_ONCHIP] = route_ff.onchip;
                  nxt_prdata[XCA_BIT_CAN]    = route_ff.can_sel;
                  nxt_prdata[XCA_BIT_EA]     = ea_sync;
               end
               default:
               begin
                  nxt_prdata = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff  <= nxt_prdata;
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign acc_done  = done_ff;
   assign acc_route = route_ff;
   assign acc_rdata = rdata_ff;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_win_ptr;
      acc_req && acc_cmd.use_pointer && (acc_cmd.pointer < XCA_WIN_LO)
         |=> !acc_route.onchip && acc_route.low_port_bus && acc_route.high_port_bus;
   endproperty
   a_win_ptr: assert property (p_win_ptr) else $error("pointer below window routed on-chip");

   property p_gdis_ext;
      acc_req && gdis_ff |=> !acc_route.onchip;
   endproperty
   a_gdis_ext: assert property (p_gdis_ext) else $error("on-chip used while disabled");

   property p_gdis_sticky;
      !gdis_ff |=> !gdis_ff;
   endproperty
   a_gdis_sticky: assert property (p_gdis_sticky) else $error("disable bit set again");

   property p_hidden;
      acc_req && !vis_ff && !gdis_ff && !acc_cmd.use_pointer && (page_ff >= XCA_WIN_PAGE)
         |=> acc_route.onchip && !acc_route.rd_strobe_en && !acc_route.wr_strobe_en;
   endproperty
   a_hidden: assert property (p_hidden) else $error("strobes active on hidden hit");

   property p_visible;
      acc_done && acc_route.onchip && $past(vis_ff)
         |-> (acc_route.rd_strobe_en || acc_route.wr_strobe_en) && acc_route.low_port_bus;
   endproperty
   a_visible: assert property (p_visible) else $error("visible hit not exposed");

   property p_page_addr;
      acc_req && !acc_cmd.use_pointer |=> acc_route.addr == {$past(page_ff), $past(acc_cmd.index)};
   endproperty
   a_page_addr: assert property (p_page_addr) else $error("indexed address wrong");

   property p_ext_strobe;
      acc_done && !acc_route.onchip |-> acc_route.rd_strobe_en || acc_route.wr_strobe_en;
   endproperty
   a_ext_strobe: assert property (p_ext_strobe) else $error("external access without strobe");

   property p_p2_idx;
      acc_req && !acc_cmd.use_pointer |=> !acc_route.high_port_bus;
   endproperty
   a_p2_idx: assert property (p_p2_idx) else $error("port 2 bus on indexed move");

   property p_apb_ans;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("apb answer timing wrong");

   c_hidden_hit: cover property (acc_done && acc_route.onchip && !acc_route.rd_strobe_en
                                 && !acc_route.wr_strobe_en);
   c_visible_hit: cover property (acc_done && acc_route.onchip && acc_route.wr_strobe_en);
   c_can_hit: cover property (acc_done && acc_route.can_sel);
   c_unlock: cover property ($fell(gdis_ff));

endmodule
`default_nettype wire

/* testbench/xca_ext_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module xca_ext_mem
   import xca_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       acc_done,
   input  wire xca_route_s acc_route,
   output logic [15:0]     ext_hits
);

   // Off-chip memory sees only the cycles the block does not route on-chip
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         ext_hits <= 16'h0000;
      else if (acc_done && !acc_route.onchip)
         ext_hits <= ext_hits + 16'h0001;
   end

endmodule

`default_nettype wire

/* testbench/tb_xca_access_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_xca_access_ctrl
   import xca_pkg::*;
;
   logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        acc_req = 0, pin = 0, pin_s = 0;
   logic [7:0]  paddr = 0, page = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, acc_done;
   xca_req_s    acc_cmd = '0;
   xca_route_s  acc_route;
   logic [7:0]  acc_rdata;
   logic [15:0] ext_hits;
   logic        gdis = 1, vis = 0, lonc = 0, lcan = 0;
   logic [7:0]  ram [int];
   logic [32:0] q_apb [$];
   logic [29:0] q_acc [$];
   logic [15:0] ptrs [5] = '{16'h0000, 16'hF6FF, 16'hF700, 16'hF800, 16'hFFFF};
   logic [7:0]  pgs [4] = '{8'hF6, 8'hF7, 8'hF8, 8'hFF};
   int          fail_count = 0, samples_checked = 0, exp_ext = 0;

   always #50 mclk = ~mclk;

   xca_access_ctrl u_xca_access_ctrl (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .acc_req(acc_req), .acc_cmd(acc_cmd),
      .acc_done(acc_done), .acc_route(acc_route), .acc_rdata(acc_rdata),
      .external_access_select_pin(pin));

   xca_ext_mem u_xca_ext_mem (.mclk(mclk), .sys_rst(sys_rst), .acc_done(acc_done),
      .acc_route(acc_route), .ext_hits(ext_hits));

   task chk_apb(input logic [32:0] e, input logic [32:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected register result at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   task chk_acc(input logic [29:0] e, input logic [29:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected route at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   function logic [32:0] regval(input logic [7:0] a);
      case (a)
         XCA_OFS_SYSCTL: return {31'h0, vis, gdis};
         XCA_OFS_PAGE:   return {25'h0, page};
         XCA_OFS_STATUS: return {30'h0, pin_s, lcan, lonc};
         default:        return {1'b1, 32'h0};
      endcase
   endfunction

   // APB master; request held until pready is seen at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic [32:0] e;
      e = regval(a);
      if (w)
         e[31:0] = 32'h0;
      q_apb.push_back(e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // No wait state count is assumed; only the watchdog ends a stuck access
      @(posedge mclk);
      while (!pready)
      begin
         @(posedge mclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && a == XCA_OFS_SYSCTL)
      begin
         vis = d[1];
         gdis = gdis & d[0];
      end
      if (w && a == XCA_OFS_PAGE)
         page = d[7:0];
   endtask

   // One data move; reads of unwritten RAM become writes
   task acc(input logic up, input logic wr, input logic [15:0] ptr, input logic [7:0] ix,
            input logic [7:0] wd);
      logic [15:0] a;
      logic        onc, can, en, low;
      logic [7:0]  rd;
      a = up ? ptr : {page, ix};
      onc = (up ? ptr >= XCA_WIN_LO : page >= XCA_WIN_PAGE) & ~gdis;
      can = onc & (a[15:8] == XCA_CAN_PAGE);
      if (onc && !can && !wr && !ram.exists(a[10:0]))
         wr = 1'b1;
      en = ~onc | vis;
      low = ~(onc & ~vis & pin_s);
      rd = 8'h00;
      if (onc && !can && wr)
         ram[a[10:0]] = wd;
      else if (onc && !can)
         rd = ram[a[10:0]];
      exp_ext += int'(!onc);
      lonc = onc;
      lcan = can;
      q_acc.push_back({a, onc, can, low, up & low, en & ~wr, en & wr, rd});
      @(posedge mclk);
      acc_req <= 1'b1;
      acc_cmd <= {up, wr, ptr, ix, wd};
   endtask

   task acc_stop();
      @(posedge mclk);
      acc_req <= 1'b0;
   endtask

   task setpin(input logic v);
      @(posedge mclk);
      pin <= v;
      repeat (4) @(posedge mclk);
      pin_s = v;
   endtask

   // Pointer and page sweeps across the window edges, back to back
   task sweep();
      logic [7:0] ix;
      for (int i = 0; i < 5; i++)
      begin
         acc(1'b1, 1'b1, ptrs[i], 8'h00, 8'($urandom));
         acc(1'b1, 1'b0, ptrs[i], 8'h00, 8'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         acc_stop();
         apb(1'b1, XCA_OFS_PAGE, {24'h0, pgs[i]});
         ix = 8'($urandom);
         acc(1'b0, 1'b1, 16'h0000, ix, 8'($urandom));
         acc(1'b0, 1'b0, 16'h0000, ix, 8'h00);
      end
      acc_stop();
   endtask

   task close_out();
      if (q_apb.size() + q_acc.size() != 0)
         fail_count++;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Results compared against the oldest note as they appear
   always @(posedge mclk)
   begin
      if (psel && penable && pready)
         chk_apb(q_apb.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
      if (acc_done)
         chk_acc(q_acc.pop_front(), {acc_route, acc_rdata});
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      close_out();
   end

   initial
   begin
      void'($urandom(27336));
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      apb(1'b0, XCA_OFS_SYSCTL, 32'h0);
      apb(1'b0, XCA_OFS_PAGE, 32'h0);
      sweep();
      $display("test disabled window done");
      for (int m = 0; m < 4; m++)
      begin
         setpin(m[1]);
         apb(1'b1, XCA_OFS_SYSCTL, m[0] ? 32'h2 : 32'h0);
         sweep();
         apb(1'b0, XCA_OFS_STATUS, 32'h0);
      end
      $display("test mode table done");
      apb(1'b1, XCA_OFS_SYSCTL, 32'h3);
      apb(1'b0, XCA_OFS_SYSCTL, 32'h0);
      apb(1'b1, XCA_OFS_PAGE, 32'($urandom_range(240, 255)));
      repeat (40)
         acc(1'($urandom), 1'($urandom), 16'hF600 + 16'($urandom_range(0, 2559)),
             8'($urandom), 8'($urandom));
      acc_stop();
      $display("test random done");
      apb(1'b0, 8'h0C, 32'h0);
      apb(1'b1, 8'h0C, 32'hFFFFFFFF);
      apb(1'b1, XCA_OFS_STATUS, 32'h7);
      apb(1'b0, XCA_OFS_STATUS, 32'h0);
      chk_apb({17'h0, 16'(exp_ext)}, {17'h0, ext_hits});
      $display("test register map done");
      setpin(1'b0);
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      gdis = 1'b1;
      vis = 1'b0;
      page = 8'h00;
      lonc = 1'b0;
      lcan = 1'b0;
      apb(1'b0, XCA_OFS_SYSCTL, 32'h0);
      acc(1'b1, 1'b0, 16'hF800, 8'h00, 8'h00);
      acc_stop();
      repeat (2) @(posedge mclk);
      $display("test second reset done");
      close_out();
   end

endmodule

`default_nettype wire
